// *** hdl/sptr_pkg.sv ***
package sptr_pkg;

  // source selector codes for a differential trigger line
  typedef enum logic [1:0] {
    SPTR_SRC_EXT = 2'h0, // inverted copy of the front sync output
    SPTR_SRC_REF = 2'h1, // reference oscillator clock
    SPTR_SRC_STB = 2'h2  // pulse per converter strobe
  } sptr_src_t;

  // per-line configuration carried as one unit
  typedef struct packed {
    logic en;       // line output enable
    sptr_src_t src; // selected source
  } sptr_line_cfg_t;

  localparam int SPTR_LINES = 2;

  // register byte offsets
  localparam logic [7:0] SPTR_OFS_CTRL = 8'h00;
  localparam logic [7:0] SPTR_OFS_SRC = 8'h04;
  localparam logic [7:0] SPTR_OFS_STAT = 8'h08;
  localparam logic [7:0] SPTR_OFS_CMD = 8'h0C;

  // control register fields
  localparam int SPTR_CTRL_EN0 = 0;
  localparam int SPTR_CTRL_EN1 = 1;
  localparam int SPTR_CTRL_FRONT_EN = 2;
  // source register fields: two bits per line
  localparam int SPTR_SRC_W = 2;
  // status register fields
  localparam int SPTR_STAT_INIT = 0;
  localparam int SPTR_STAT_REFUSED = 1;
  localparam int SPTR_STAT_LINE0 = 2;
  localparam int SPTR_STAT_LINE1 = 3;
  // command register field
  localparam int SPTR_CMD_ONESHOT = 0;

  // reset values
  localparam sptr_src_t SPTR_RST_SRC0 = SPTR_SRC_STB;
  localparam sptr_src_t SPTR_RST_SRC1 = SPTR_SRC_EXT;
  localparam logic SPTR_RST_EN = 1'b0;

  // strobe pulse timing
  localparam int SPTR_CLK_MHZ = 40;
  localparam int SPTR_PULSE_NS = 25;
  localparam int SPTR_PULSE_CYC_RAW =
    (SPTR_PULSE_NS * SPTR_CLK_MHZ + 999) / 1000;
  localparam int SPTR_PULSE_CYC =
    (SPTR_PULSE_CYC_RAW < 1) ? 1 : SPTR_PULSE_CYC_RAW;
  localparam int SPTR_CNT_W = 4;

endpackage : sptr_pkg

// *** hdl/sptr_router.sv ***
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module sptr_router (
  input wire logic clk_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // same-domain sources
  input wire logic front_sync_sig_in,
  input wire logic ref_is_external_in,
  input wire logic adc_strobe_in,
  input wire logic readout_strobe_in,
  input wire logic trig_initiated_in,
  // reference oscillator arrives from a pin
  input wire logic reference_osc_clock_in,
  // differential trigger lines
  output logic [1:0] diff_trigger_line_out,
  output logic front_sync_en_out
);

  // reset release synchroniser
  logic rst_s1_ff;
  logic rst_s2_ff;
  logic rstn;

  // reference clock pin synchroniser
  logic ref_s1_ff;
  logic ref_s2_ff;

  // configuration state
  sptr_pkg::sptr_line_cfg_t cfg_ff [sptr_pkg::SPTR_LINES];
  sptr_pkg::sptr_line_cfg_t nxt_cfg [sptr_pkg::SPTR_LINES];
  logic front_en_ff;
  logic nxt_front_en;
  logic refused_ff;
  logic nxt_refused;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [sptr_pkg::SPTR_CNT_W-1:0] pulse_cnt_ff;
  logic [sptr_pkg::SPTR_CNT_W-1:0] nxt_pulse_cnt;
  logic [1:0] line_ff;
  logic [1:0] nxt_line;

  // bus decode
  wire setup_ph = psel_in & ~penable_in;
  wire acc_ph = psel_in & penable_in;
  wire hit_ctrl = (paddr_in == sptr_pkg::SPTR_OFS_CTRL);
  wire hit_src = (paddr_in == sptr_pkg::SPTR_OFS_SRC);
  wire hit_stat = (paddr_in == sptr_pkg::SPTR_OFS_STAT);
  wire hit_cmd = (paddr_in == sptr_pkg::SPTR_OFS_CMD);
  wire mapped = hit_ctrl | hit_src | hit_stat | hit_cmd;
  wire wr_ok = acc_ph & pwrite_in & mapped;
  wire wr_ctrl = wr_ok & hit_ctrl;
  wire wr_src = wr_ok & hit_src;
  wire wr_stat = wr_ok & hit_stat;
  // one-shot one_shot_cmd_a command strobe
  wire oneshot = wr_ok & hit_cmd & pwdata_in[sptr_pkg::SPTR_CMD_ONESHOT];
  // source writes only land while the trigger system is idle
  wire src_take = wr_src & ~trig_initiated_in;
  wire src_refuse = wr_src & trig_initiated_in;

  // converter strobes, including those from memory readout
  wire strobe_any = adc_strobe_in | readout_strobe_in;
  // pulse stretcher output, a single shared pulse for both lines
  wire stb_pulse = (pulse_cnt_ff != 4'h0);
  // the pin synchroniser costs two cycles of phase against the pin
  // reference level, inverted for an external reference so the
  // line rises on its falling edge
  wire ref_level = ref_is_external_in ? ~ref_s2_ff : ref_s2_ff;
  // inverted front sync, gated by the front enable
  wire ext_level = front_en_ff & ~front_sync_sig_in;

  assign rstn = rst_s2_ff;
  // zero wait states: the slave answers in the first access cycle
  assign pready_out = 1'b1;
  // an unmapped address is flagged but otherwise harmless
  assign pslverr_out = acc_ph & ~mapped;
  assign prdata_out = rdata_ff;
  assign diff_trigger_line_out = line_ff;
  assign front_sync_en_out = front_en_ff;

  // reset is asserted at once, released after two edges
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // pin synchroniser; only the second stage is read
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
    end else begin
      ref_s1_ff <= reference_osc_clock_in;
      ref_s2_ff <= ref_s1_ff;
    end
  end

  // next configuration; one-shot wins over any other write
  always_comb begin
    nxt_front_en = front_en_ff;
    for (int i = 0; i < sptr_pkg::SPTR_LINES; i++) begin
      nxt_cfg[i] = cfg_ff[i];
    end
    if (oneshot) begin
      // all outputs off, feeds back to reset values
      nxt_front_en = sptr_pkg::SPTR_RST_EN;
      nxt_cfg[0].en = sptr_pkg::SPTR_RST_EN;
      nxt_cfg[1].en = sptr_pkg::SPTR_RST_EN;
      nxt_cfg[0].src = sptr_pkg::SPTR_RST_SRC0;
      nxt_cfg[1].src = sptr_pkg::SPTR_RST_SRC1;
    end else begin
      if (wr_ctrl) begin
        // independent enables per line
        nxt_cfg[0].en = pwdata_in[sptr_pkg::SPTR_CTRL_EN0];
        nxt_cfg[1].en = pwdata_in[sptr_pkg::SPTR_CTRL_EN1];
        nxt_front_en = pwdata_in[sptr_pkg::SPTR_CTRL_FRONT_EN];
      end
      if (src_take) begin
        for (int i = 0; i < sptr_pkg::SPTR_LINES; i++) begin
          // a field holding the unused code keeps the old source
          if (pwdata_in[i*2 +: 2] != 2'h3) begin
            nxt_cfg[i].src =
              sptr_pkg::sptr_src_t'(pwdata_in[i*2 +: 2]);
          end
        end
      end
    end
  end

  // refused-write flag: a new refusal wins over the clear
  assign nxt_refused = src_refuse |
    (refused_ff & ~(wr_stat & pwdata_in[sptr_pkg::SPTR_STAT_REFUSED]));

  // read data captured during the setup cycle
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      nxt_rdata[sptr_pkg::SPTR_CTRL_EN0] = cfg_ff[0].en;
      nxt_rdata[sptr_pkg::SPTR_CTRL_EN1] = cfg_ff[1].en;
      nxt_rdata[sptr_pkg::SPTR_CTRL_FRONT_EN] = front_en_ff;
    end else if (hit_src) begin
      nxt_rdata[1:0] = cfg_ff[0].src;
      nxt_rdata[3:2] = cfg_ff[1].src;
    end else if (hit_stat) begin
      nxt_rdata[sptr_pkg::SPTR_STAT_INIT] = trig_initiated_in;
      nxt_rdata[sptr_pkg::SPTR_STAT_REFUSED] = refused_ff;
      nxt_rdata[sptr_pkg::SPTR_STAT_LINE0] = line_ff[0];
      nxt_rdata[sptr_pkg::SPTR_STAT_LINE1] = line_ff[1];
    end
  end

  // strobe pulse stretcher: a strobe reloads the width count
  // a strobe landing mid-pulse restarts the width, so a train of
  // back-to-back strobes keeps the line high rather than chopping it
  assign nxt_pulse_cnt = strobe_any ?
    4'(sptr_pkg::SPTR_PULSE_CYC) :
    (stb_pulse ? pulse_cnt_ff - 4'h1 : 4'h0);

  // per-line source mux; a disabled line sits low
  always_comb begin
    for (int i = 0; i < sptr_pkg::SPTR_LINES; i++) begin
      nxt_line[i] = 1'b0;
      if (cfg_ff[i].en) begin
        unique case (cfg_ff[i].src)
          sptr_pkg::SPTR_SRC_EXT: nxt_line[i] = ext_level;
          // clock follows with no gaps while selected
          sptr_pkg::SPTR_SRC_REF: nxt_line[i] = ref_level;
          sptr_pkg::SPTR_SRC_STB: nxt_line[i] = stb_pulse;
          default: nxt_line[i] = 1'b0;
        endcase
      end
    end
  end

  // configuration registers; reset gives the documented feeds
  // the enable and source share one packed word per line
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      cfg_ff[0] <= {sptr_pkg::SPTR_RST_EN, sptr_pkg::SPTR_RST_SRC0};
      cfg_ff[1] <= {sptr_pkg::SPTR_RST_EN, sptr_pkg::SPTR_RST_SRC1};
      front_en_ff <= 1'b0;
    end else begin
      cfg_ff[0] <= nxt_cfg[0];
      cfg_ff[1] <= nxt_cfg[1];
      front_en_ff <= nxt_front_en;
    end
  end

  // status, read data, pulse counter and line outputs
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      refused_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      pulse_cnt_ff <= 4'h0;
      line_ff <= 2'h0;
    end else begin
      refused_ff <= nxt_refused;
      if (setup_ph) begin
        rdata_ff <= nxt_rdata;
      end
      pulse_cnt_ff <= nxt_pulse_cnt;
      line_ff <= nxt_line;
    end
  end

  // checks, one clock domain
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rstn);

  // one-shot: config resets at once, the lines follow a cycle later
  property p_oneshot;
    oneshot |=> !front_en_ff && !cfg_ff[0].en && !cfg_ff[1].en &&
      cfg_ff[0].src == sptr_pkg::SPTR_SRC_STB &&
      cfg_ff[1].src == sptr_pkg::SPTR_SRC_EXT ##1 line_ff == 2'h0;
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("one-shot did not clear outputs");

  property p_refuse;
    src_refuse && !oneshot |=> $stable({cfg_ff[0].src, cfg_ff[1].src});
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("source changed while initiated");

  property p_refused_flag;
    src_refuse |=> refused_ff;
  endproperty
  a_refused_flag: assert property (p_refused_flag)
    else $error("refused write not flagged");

  // a write-one clear drops the flag unless a refusal lands with it
  property p_refused_clear;
    wr_stat && pwdata_in[sptr_pkg::SPTR_STAT_REFUSED] && !src_refuse |=>
      !refused_ff;
  endproperty
  a_refused_clear: assert property (p_refused_clear)
    else $error("refused flag not cleared");

  // one control write sets both line enables and the front enable
  property p_en_write;
    wr_ctrl |=>
      cfg_ff[0].en == $past(pwdata_in[sptr_pkg::SPTR_CTRL_EN0]) &&
      cfg_ff[1].en == $past(pwdata_in[sptr_pkg::SPTR_CTRL_EN1]) &&
      front_en_ff == $past(pwdata_in[sptr_pkg::SPTR_CTRL_FRONT_EN]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable write lost");

  generate
    // per-line checks; both lines share one set of property shapes
    for (genvar g = 0; g < 2; g++) begin : g_chk
      // the line's enable is off
      sequence s_off;
        !cfg_ff[g].en;
      endsequence

      property p_off_low;
        s_off |=> !line_ff[g];
      endproperty
      a_off_low: assert property (p_off_low)
        else $error("disabled line not low");

      property p_ext;
        cfg_ff[g].en && cfg_ff[g].src == sptr_pkg::SPTR_SRC_EXT |=>
          line_ff[g] == ($past(front_en_ff) && !$past(front_sync_sig_in));
      endproperty
      a_ext: assert property (p_ext)
        else $error("external copy wrong");

      property p_ext_gate;
        cfg_ff[g].src == sptr_pkg::SPTR_SRC_EXT && !front_en_ff |=>
          !line_ff[g];
      endproperty
      a_ext_gate: assert property (p_ext_gate)
        else $error("external copy without front enable");

      property p_ref;
        cfg_ff[g].en && cfg_ff[g].src == sptr_pkg::SPTR_SRC_REF |=>
          line_ff[g] == ($past(ref_s2_ff) ^ $past(ref_is_external_in));
      endproperty
      a_ref: assert property (p_ref)
        else $error("reference clock polarity wrong");

      sequence s_stb_sel;
        cfg_ff[g].en && cfg_ff[g].src == sptr_pkg::SPTR_SRC_STB;
      endsequence

      property p_stb;
        s_stb_sel ##0 strobe_any ##1 s_stb_sel |=> line_ff[g];
      endproperty
      a_stb: assert property (p_stb)
        else $error("strobe pulse missing");

      property p_stb_width;
        s_stb_sel ##0 !strobe_any ##1 !strobe_any |=> !line_ff[g];
      endproperty
      a_stb_width: assert property (p_stb_width)
        else $error("strobe pulse too wide");

      // memory readout strobes light the line just like conversions
      property p_rdo;
        s_stb_sel ##0 readout_strobe_in ##1 s_stb_sel |=> line_ff[g];
      endproperty
      a_rdo: assert property (p_rdo)
        else $error("readout strobe pulse missing");

      // a legal field replaces this line's source and nothing else
      property p_src_take;
        src_take && pwdata_in[g*2 +: 2] != 2'h3 |=>
          cfg_ff[g].src == $past(pwdata_in[g*2 +: 2]);
      endproperty
      a_src_take: assert property (p_src_take)
        else $error("source write lost");

      // the spare code leaves the line's source alone
      property p_src_keep;
        src_take && pwdata_in[g*2 +: 2] == 2'h3 |=> $stable(cfg_ff[g].src);
      endproperty
      a_src_keep: assert property (p_src_keep)
        else $error("spare source code changed the line");

      // only the three source codes ever sit in a selector
      property p_src_legal;
        cfg_ff[g].src inside {sptr_pkg::SPTR_SRC_EXT, sptr_pkg::SPTR_SRC_REF,
          sptr_pkg::SPTR_SRC_STB};
      endproperty
      a_src_legal: assert property (p_src_legal)
        else $error("illegal source code held");
    end
  endgenerate

endmodule : sptr_router

// *** verif/sptr_line_mon.sv ***
`timescale 1ns/1ps
// backplane receiver stand-in: it only listens, so it never drives
// the line; it counts rises and high cycles on the sampling edge
module sptr_line_mon (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic line_in,
  output logic [7:0] rise_out,
  output logic [7:0] high_out
);
  logic prev_ff; // level seen at the previous edge
  // a glitch narrower than a cycle is missed, same as a slow receiver
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_ff <= 1'b0;
      rise_out <= 8'h00;
      high_out <= 8'h00;
    end else begin
      prev_ff <= line_in;
      if (line_in && !prev_ff) begin // new rising level
        rise_out <= rise_out + 8'h01;
      end
      if (line_in) begin // width in whole cycles
        high_out <= high_out + 8'h01;
      end
    end
  end
endmodule : sptr_line_mon

// *** verif/sptr_router_bench.sv ***
`timescale 1ns/1ps
module sptr_router_bench;
  logic clk_in, resetn_in, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, rise, high, r0, h0;
  logic [31:0] pwdata, prdata, rd, seed;
  logic fsig, ref_ext, adc, rdo, trig, ref_pin, fen;
  logic [1:0] line; // both trigger lines
  int mismatches, num_checks;

  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  sptr_router uut (.clk_in(clk_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .front_sync_sig_in(fsig), .ref_is_external_in(ref_ext),
    .adc_strobe_in(adc), .readout_strobe_in(rdo),
    .trig_initiated_in(trig), .reference_osc_clock_in(ref_pin),
    .diff_trigger_line_out(line), .front_sync_en_out(fen));

  // line 0 is the one whose pulses are counted
  sptr_line_mon mon (.clk_in(clk_in), .resetn_in(resetn_in),
    .line_in(line[0]), .rise_out(rise), .high_out(high));

  // xorshift step for repeatable random stimulus
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task conclude;
    $display("mismatches=%0d checks=%0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask : chk

  // one apb transfer; result left in rd and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin // bounded wait for pready
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      mismatches++;
      conclude();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // one-cycle strobe, then room for the pulse to pass
  task strobe(input logic conv);
    @(posedge clk_in);
    if (conv) adc <= 1'b1;
    else rdo <= 1'b1;
    @(posedge clk_in);
    adc <= 1'b0;
    rdo <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : strobe

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    conclude();
  end

  initial begin
    {resetn_in, psel, penable, pwrite, fsig, ref_ext} = 6'h00;
    {adc, rdo, trig, ref_pin} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h000040DE; // 16606
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in); // internal reset sync settles
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    chk({30'h0, line}, 32'h0);
    apb(1'b0, 8'h40, 32'h0); // unmapped
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    r0 = rise;
    strobe(1'b1); // disabled line must stay quiet
    chk(32'(rise), 32'(r0));
    apb(1'b1, 8'h00, 32'h1);
    r0 = rise;
    h0 = high;
    strobe(1'b1);
    strobe(1'b0);
    chk(32'(rise), 32'(r0) + 32'h2);
    chk(32'(high), 32'(h0) + 32'h2);
    // line 1 copies front sync inverted, only with both enables
    apb(1'b1, 8'h00, 32'h3);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      if (i == 8) apb(1'b1, 8'h00, 32'h7);
      @(posedge clk_in);
      fsig <= seed[0];
      repeat (2) @(posedge clk_in);
      chk({31'h0, line[1]}, {31'h0, (i >= 8) && !seed[0]});
    end
    chk({31'h0, fen}, 32'h1);
    // source change while initiated is refused and flagged
    trig <= 1'b1;
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h3, 32'h3);
    trig <= 1'b0;
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h3, 32'h0);
    apb(1'b1, 8'h04, 32'h6);
    apb(1'b1, 8'h04, 32'h3); // line 0 field 3 keeps its source
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    // reference clock on line 0, both edge polarities
    apb(1'b1, 8'h04, 32'h1);
    for (int e = 0; e < 2; e++) begin
      ref_ext <= e[0];
      repeat (6) @(posedge clk_in);
      r0 = rise;
      repeat (5) begin
        ref_pin <= 1'b1;
        repeat (4) @(posedge clk_in);
        ref_pin <= 1'b0;
        repeat (4) @(posedge clk_in);
      end
      repeat (6) @(posedge clk_in);
      chk(32'(rise), 32'(r0) + 32'h5);
      chk({31'h0, line[0]}, 32'(e));
    end
    // one-shot clears enables and restores sources
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    chk({31'h0, fen}, 32'h0);
    chk({30'h0, line}, 32'h0);
    // mid-run reset must bring back the power-up defaults
    apb(1'b1, 8'h00, 32'h7);
    apb(1'b1, 8'h04, 32'h5);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    chk({30'h0, line}, 32'h0);
    conclude();
  end
endmodule : sptr_router_bench
